// ---- core/spms_pkg.sv ----
// constants, register map and state codes of the serial port
package spms_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_BAUD = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0C;
    localparam logic [7:0] OFS_DATA = 8'h10;

    // ------------------------------------------------------------
    // port_control_one fields
    // ------------------------------------------------------------
    localparam int C1_RIE = 7;
    localparam int C1_EN = 6;
    localparam int C1_TIE = 5;
    localparam int C1_MASTER_SLAVE_SELECT = 4;
    localparam int C1_CPOL = 3;
    localparam int C1_CPHA = 2;
    localparam int C1_SELECT_OUTPUT_ENABLE = 1;
    localparam int C1_LSBF = 0;

    // ------------------------------------------------------------
    // second control, baud and status fields
    // ------------------------------------------------------------
    localparam int C2_MODE_FAULT_ENABLE = 4;
    localparam int C2_BIDIR = 3;
    localparam int C2_SWIRE = 0;
    localparam int BR_PRE_LSB = 4;
    localparam int BR_RATE_LSB = 0;
    localparam int ST_RXF = 7;
    localparam int ST_TXE = 5;
    localparam int ST_MODE_FAULT_FLAG = 4;

    // ------------------------------------------------------------
    // reset values and masks
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    localparam logic [7:0] BAUD_RST = 8'h00;
    localparam logic [7:0] CTRL2_MASK = 8'h19;
    localparam logic [7:0] BAUD_MASK = 8'h77;
    localparam logic [7:0] DATA_RST = 8'h00;

    // ------------------------------------------------------------
    // pin index in the synchroniser vector, idle levels
    // ------------------------------------------------------------
    localparam int PIN_SCK = 0;
    localparam int PIN_MOSI = 1;
    localparam int PIN_MISO = 2;
    localparam int PIN_SS = 3;
    localparam logic [3:0] PIN_IDLE = 4'h8;

    // ------------------------------------------------------------
    // timing: clock edges per byte
    // ------------------------------------------------------------
    localparam logic [4:0] EDGE_FIRST = 5'h00;
    localparam logic [4:0] EDGE_LAST = 5'h0F;
    localparam logic [4:0] EDGE_END = 5'h10;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_RUN = 2'b10
    } spms_state_t;

endpackage : spms_pkg

// ---- core/spms_port.sv ----
// serial port, master or slave, with apb register file
`timescale 1ns/100ps
// ------------------------------------------------------------
// Overview of operation
// - data write fills tx buffer; finished byte lands in rx buffer for reads
// - master drives clock pin and mosi, samples miso
// - slave clocks from clock pin, drives miso, samples mosi
// - master bit clock is bus clock over prescale then rate divisor
// - prescale field n divides by n+1, rate field by 2^(n+1)
// - port disabled releases all four pins
// - single-wire master uses mosi, direction set by bidir enable
// - single-wire slave leaves mosi to general-purpose control
// - single-wire slave uses miso, direction set by bidir enable
// - single-wire master leaves miso to general-purpose control
// - select pin: slave input, or master fault input, output or unused
// - deep stop powers down; wake-up returns reset state
// - shallow stop freezes everything; interrupt exit resumes as held
// - receive enable requests interrupt on rx full or mode fault
// - clearing enable aborts, empties buffers, clears rx full, sets tx empty
// - transmit enable requests interrupt while tx buffer empty
// - master select bit: 0 slave, 1 master
// - polarity bit inverts clock; 0 idles low, 1 idles high
// - phase 0 first edge mid bit, phase 1 at bit start
// - bit order 0 msb first, 1 lsb first
// ------------------------------------------------------------
module spms_port #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // stop mode requests
    input wire logic STOP_SHALLOW,
    input wire logic STOP_DEEP,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // interrupt request
    output logic IRQ,
    // serial clock pin
    input wire logic SCK_IN,
    output logic SCK_OUT,
    output logic SCK_OE,
    // mosi pin
    input wire logic MOSI_IN,
    output logic MOSI_OUT,
    output logic MOSI_OE,
    // miso pin
    input wire logic MISO_IN,
    output logic MISO_OUT,
    output logic MISO_OE,
    // select pin
    input wire logic SS_IN,
    output logic SS_OUT,
    output logic SS_OE
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_bad_addr
        $error("spms_port: ADDR_W must lie between 5 and 32");
    end

    // ------------------------------------------------------------
    // reset and stop
    // ------------------------------------------------------------
    // deep stop loses all state, so it acts as a reset
    wire rst_any = RST | STOP_DEEP;
    wire hold = STOP_SHALLOW;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] ctrl1_r, ctrl1_nxt, ctrl2_r, ctrl2_nxt, baud_r, baud_nxt;
    logic [7:0] tx_buf_r, tx_buf_nxt, rx_buf_r, rx_buf_nxt, sh_r, sh_nxt;
    logic [7:0] prdata_r, prdata_nxt;
    logic tx_empty_r, tx_empty_nxt, rx_full_r, rx_full_nxt, mode_fault_flag_r, mode_fault_flag_nxt;
    logic smp_r, smp_nxt, sck_r, sck_nxt, sck_prev_r;
    logic [4:0] edge_r, edge_nxt;
    logic [2:0] pre_cnt_r, pre_cnt_nxt;
    logic [7:0] half_cnt_r, half_cnt_nxt, evt_gap_r;
    logic [3:0] s1_r, s2_r, s3_r, pin_f_r, pin_f_nxt;
    spms_pkg::spms_state_t state_r, state_nxt;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc = PSEL & PENABLE;
    wire wr_acc = acc & PWRITE;
    wire rd_acc = acc & ~PWRITE;
    wire sel_c1 = PADDR == ADDR_W'(spms_pkg::OFS_CTRL1);
    wire sel_c2 = PADDR == ADDR_W'(spms_pkg::OFS_CTRL2);
    wire sel_br = PADDR == ADDR_W'(spms_pkg::OFS_BAUD);
    wire sel_st = PADDR == ADDR_W'(spms_pkg::OFS_STAT);
    wire sel_dt = PADDR == ADDR_W'(spms_pkg::OFS_DATA);
    wire mapped = sel_c1 | sel_c2 | sel_br | sel_st | sel_dt;
    wire [7:0] wdat = PWDATA[7:0];
    wire wr_data = wr_acc & sel_dt & mapped;
    wire rd_data = rd_acc & sel_dt;
    wire mode_fault_flag_clr = wr_acc & sel_st & wdat[spms_pkg::ST_MODE_FAULT_FLAG];
    wire [7:0] stat_val = {rx_full_r, 1'b0, tx_empty_r, mode_fault_flag_r, 4'h0};

    assign PREADY = acc;
    assign PSLVERR = acc & ~mapped;
    assign PRDATA = {24'h000000, prdata_r};

    // read data is captured in the setup phase, so no wait state
    assign prdata_nxt = ~(PSEL & ~PENABLE) ? prdata_r :
                        sel_c1 ? ctrl1_r :
                        sel_c2 ? ctrl2_r :
                        sel_br ? baud_r :
                        sel_st ? stat_val :
                        sel_dt ? rx_buf_r : 8'h00;

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    wire en = ctrl1_r[spms_pkg::C1_EN];
    wire master_slave_select = ctrl1_r[spms_pkg::C1_MASTER_SLAVE_SELECT];
    wire cpol = ctrl1_r[spms_pkg::C1_CPOL];
    wire cpha = ctrl1_r[spms_pkg::C1_CPHA];
    wire select_output_enable = ctrl1_r[spms_pkg::C1_SELECT_OUTPUT_ENABLE];
    wire lsbf = ctrl1_r[spms_pkg::C1_LSBF];
    wire mode_fault_enable = ctrl2_r[spms_pkg::C2_MODE_FAULT_ENABLE];
    wire bidir = ctrl2_r[spms_pkg::C2_BIDIR];
    wire swire = ctrl2_r[spms_pkg::C2_SWIRE];
    wire is_master = en & master_slave_select;
    wire is_slave = en & ~master_slave_select;
    wire running = state_r == spms_pkg::ST_RUN;

    // ------------------------------------------------------------
    // pin synchronisers, a change counts once stages two and three agree
    // ------------------------------------------------------------
    wire [3:0] pin_raw = {SS_IN, MISO_IN, MOSI_IN, SCK_IN};
    wire [3:0] pin_agree = ~(s2_r ^ s3_r);
    assign pin_f_nxt = (s3_r & pin_agree) | (pin_f_r & ~pin_agree);
    wire sck_f = pin_f_r[spms_pkg::PIN_SCK];
    wire mosi_f = pin_f_r[spms_pkg::PIN_MOSI];
    wire miso_f = pin_f_r[spms_pkg::PIN_MISO];
    wire ss_f = pin_f_r[spms_pkg::PIN_SS];

    // ------------------------------------------------------------
    // master bit-rate generator
    // ------------------------------------------------------------
    wire [2:0] pre_div = baud_r[spms_pkg::BR_PRE_LSB +: 3];
    wire [2:0] rate = baud_r[spms_pkg::BR_RATE_LSB +: 3];
    // half a bit is 2^rate prescaled ticks, so a full bit is 2^(rate+1)
    wire [7:0] half_span = 8'h01 << rate;
    wire pre_tick = pre_cnt_r == pre_div;
    wire half_tick = pre_tick & (half_cnt_r == half_span - 8'h01);
    assign pre_cnt_nxt = (~running | pre_tick) ? 3'h0 : pre_cnt_r + 3'h1;
    assign half_cnt_nxt = (~running | half_tick) ? 8'h00 :
                          pre_tick ? half_cnt_r + 8'h01 : half_cnt_r;

    // ------------------------------------------------------------
    // shift events
    // ------------------------------------------------------------
    wire m_evt = is_master & running & half_tick;
    wire m_edge = m_evt & (edge_r != spms_pkg::EDGE_END);
    wire m_end = m_evt & (edge_r == spms_pkg::EDGE_END);
    wire s_evt = is_slave & running & ~ss_f & (sck_f ^ sck_prev_r);
    wire data_evt = m_edge | s_evt;
    wire at_last = edge_r == spms_pkg::EDGE_LAST;
    // phase 0 samples on even edges, phase 1 on odd ones
    wire sample_now = data_evt & (edge_r[0] == cpha);
    wire shift_now = data_evt & ((((edge_r[0] ^ cpha)) & (edge_r != spms_pkg::EDGE_FIRST))
                     | (cpha & at_last));
    wire byte_done = data_evt & at_last;
    // master data inputs go through the synchroniser: at the fastest rates
    // the far end must set its bit about four bus cycles before the edge
    wire din = is_master ? (swire ? mosi_f : miso_f) : (swire ? miso_f : mosi_f);
    wire in_bit = sample_now ? din : smp_r;
    wire [7:0] sh_shift = lsbf ? {in_bit, sh_r[7:1]} : {sh_r[6:0], in_bit};
    wire so = lsbf ? sh_r[0] : sh_r[7];
    wire m_start = is_master & ~tx_empty_r;
    wire s_start = is_slave & ~ss_f;
    wire mode_fault_flag_evt = is_master & mode_fault_enable & ~select_output_enable & ~ss_f;

    // ------------------------------------------------------------
    // register file next values
    // ------------------------------------------------------------
    always_comb begin
        ctrl1_nxt = wr_acc & sel_c1 ? wdat : ctrl1_r;
        if (mode_fault_flag_evt) begin
            ctrl1_nxt[spms_pkg::C1_MASTER_SLAVE_SELECT] = 1'b0;
        end
    end
    assign ctrl2_nxt = wr_acc & sel_c2 ? (wdat & spms_pkg::CTRL2_MASK) : ctrl2_r;
    assign baud_nxt = wr_acc & sel_br ? (wdat & spms_pkg::BAUD_MASK) : baud_r;

    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        edge_nxt = edge_r;
        sh_nxt = sh_r;
        smp_nxt = smp_r;
        sck_nxt = sck_r;
        tx_buf_nxt = tx_buf_r;
        tx_empty_nxt = tx_empty_r;
        rx_buf_nxt = rx_buf_r;
        rx_full_nxt = rx_full_r;
        mode_fault_flag_nxt = mode_fault_flag_r;
        // software clears first, so a hardware set in the same cycle wins
        if (rd_data) begin
            rx_full_nxt = 1'b0;
        end
        if (mode_fault_flag_clr) begin
            mode_fault_flag_nxt = 1'b0;
        end
        unique case (state_r)
            spms_pkg::ST_IDLE: begin
                if (m_start | s_start) begin
                    state_nxt = spms_pkg::ST_RUN;
                    edge_nxt = spms_pkg::EDGE_FIRST;
                    sck_nxt = 1'b0;
                    if (~tx_empty_r) begin
                        sh_nxt = tx_buf_r;
                        tx_empty_nxt = 1'b1;
                    end
                end
            end
            spms_pkg::ST_RUN: begin
                if (sample_now) begin
                    smp_nxt = din;
                end
                if (shift_now) begin
                    sh_nxt = sh_shift;
                end
                if (m_edge) begin
                    sck_nxt = ~sck_r;
                end
                if (data_evt | m_evt) begin
                    edge_nxt = edge_r + 5'h01;
                end
                if (byte_done) begin
                    rx_buf_nxt = sh_shift;
                    rx_full_nxt = 1'b1;
                end
                if (m_end | (s_evt & at_last) | (is_slave & ss_f)) begin
                    state_nxt = spms_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = spms_pkg::ST_IDLE;
            end
        endcase
        // a write that meets a start refills the buffer just emptied
        if (wr_data) begin
            tx_buf_nxt = wdat;
            tx_empty_nxt = 1'b0;
        end
        if (mode_fault_flag_evt) begin
            mode_fault_flag_nxt = 1'b1;
            state_nxt = spms_pkg::ST_IDLE;
        end
        if (~en) begin
            state_nxt = spms_pkg::ST_IDLE;
            edge_nxt = spms_pkg::EDGE_FIRST;
            sck_nxt = 1'b0;
            rx_full_nxt = 1'b0;
            tx_empty_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // flip-flops; shallow stop freezes every one of them
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or posedge rst_any) begin
        if (rst_any) begin
            s1_r <= spms_pkg::PIN_IDLE;
            s2_r <= spms_pkg::PIN_IDLE;
            s3_r <= spms_pkg::PIN_IDLE;
            pin_f_r <= spms_pkg::PIN_IDLE;
            sck_prev_r <= 1'b0;
        end else if (!hold) begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_f_r <= pin_f_nxt;
            sck_prev_r <= sck_f;
        end
    end

    always_ff @(posedge REF_CLK or posedge rst_any) begin
        if (rst_any) begin
            ctrl1_r <= spms_pkg::CTRL1_RST;
            ctrl2_r <= spms_pkg::CTRL2_RST;
            baud_r <= spms_pkg::BAUD_RST;
            prdata_r <= spms_pkg::DATA_RST;
            pre_cnt_r <= 3'h0;
            half_cnt_r <= 8'h00;
        end else if (!hold) begin
            ctrl1_r <= ctrl1_nxt;
            ctrl2_r <= ctrl2_nxt;
            baud_r <= baud_nxt;
            prdata_r <= prdata_nxt;
            pre_cnt_r <= pre_cnt_nxt;
            half_cnt_r <= half_cnt_nxt;
        end
    end

    always_ff @(posedge REF_CLK or posedge rst_any) begin
        if (rst_any) begin
            state_r <= spms_pkg::ST_IDLE;
            edge_r <= spms_pkg::EDGE_FIRST;
            sh_r <= spms_pkg::DATA_RST;
            smp_r <= 1'b0;
            sck_r <= 1'b0;
            tx_buf_r <= spms_pkg::DATA_RST;
            rx_buf_r <= spms_pkg::DATA_RST;
            tx_empty_r <= 1'b1;
            rx_full_r <= 1'b0;
            mode_fault_flag_r <= 1'b0;
        end else if (!hold) begin
            state_r <= state_nxt;
            edge_r <= edge_nxt;
            sh_r <= sh_nxt;
            smp_r <= smp_nxt;
            sck_r <= sck_nxt;
            tx_buf_r <= tx_buf_nxt;
            rx_buf_r <= rx_buf_nxt;
            tx_empty_r <= tx_empty_nxt;
            rx_full_r <= rx_full_nxt;
            mode_fault_flag_r <= mode_fault_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // pin routing
    // ------------------------------------------------------------
    assign SCK_OUT = cpol ^ sck_r;
    assign SCK_OE = is_master;
    assign MOSI_OUT = so;
    assign MOSI_OE = is_master & (~swire | bidir);
    assign MISO_OUT = so;
    // slave drives miso only while selected, so shared lines stay free
    assign MISO_OE = is_slave & ~ss_f & (~swire | bidir);
    assign SS_OUT = ~running;
    assign SS_OE = is_master & mode_fault_enable & select_output_enable;
    assign IRQ = en & ((ctrl1_r[spms_pkg::C1_RIE] & (rx_full_r | mode_fault_flag_r))
                 | (ctrl1_r[spms_pkg::C1_TIE] & tx_empty_r));

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // cycles since the last master bit event, saturating
    always_ff @(posedge REF_CLK or posedge rst_any) begin
        if (rst_any) evt_gap_r <= 8'h00;
        else evt_gap_r <= m_evt ? 8'h00 : evt_gap_r + {7'h00, evt_gap_r != 8'hFF};
    end
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (rst_any);

    chk_rx_capture: assert property (byte_done && !hold |=> rx_full_r && rx_buf_r == $past(sh_shift))
        else $error("finished byte not placed in receive buffer");
    chk_tx_consume: assert property (state_r == spms_pkg::ST_IDLE && m_start && !wr_data && !hold
        && !mode_fault_flag_evt |=> tx_empty_r && running)
        else $error("master start did not take transmit buffer");
    chk_master_pins: assert property (is_master && !swire |-> SCK_OE && MOSI_OE && !MISO_OE)
        else $error("master pin routing wrong");
    chk_slave_pins: assert property (is_slave && !swire && !ss_f |-> !SCK_OE && MISO_OE && !MOSI_OE)
        else $error("slave pin routing wrong");
    chk_rate_fastest: assert property (m_edge && baud_r == 8'h00 && edge_r < 5'h0F && !hold
        && !mode_fault_flag_evt && en |=> m_evt)
        else $error("divide-by-two bit clock not every cycle");
    chk_rate_div32: assert property (m_edge && baud_r == 8'h71 && edge_r < 5'h0F && !hold && en
        && !mode_fault_flag_evt |-> ##16 (m_evt && evt_gap_r == 8'h0F))
        else $error("prescale 8 rate 4 half period is not 16 cycles");
    chk_disabled_free: assert property (!en |-> !(SCK_OE || MOSI_OE || MISO_OE || SS_OE))
        else $error("disabled port still drives a pin");
    chk_wire_master: assert property (is_master && swire |-> MOSI_OE == bidir && !MISO_OE)
        else $error("single-wire master pin use wrong");
    chk_wire_slave: assert property (is_slave && swire |-> !MOSI_OE && MISO_OE == (bidir && !ss_f))
        else $error("single-wire slave pin use wrong");
    chk_select_pin: assert property (is_slave || (is_master && !mode_fault_enable) |-> !SS_OE)
        else $error("select pin driven when it must be input or free");
    chk_auto_select: assert property (SS_OE && running |-> !SS_OUT)
        else $error("automatic select not low during byte");
    chk_stop_freeze: assert property (hold |=> $stable(state_r) && $stable(sh_r) && $stable(edge_r))
        else $error("shallow stop did not freeze state");
    chk_rx_irq: assert property (en && ctrl1_r[spms_pkg::C1_RIE] && (rx_full_r || mode_fault_flag_r) |-> IRQ)
        else $error("receive interrupt missing");
    chk_tx_irq: assert property (en && ctrl1_r[spms_pkg::C1_TIE] && tx_empty_r |-> IRQ)
        else $error("transmit interrupt missing");
    chk_disable_flush: assert property ($fell(en) && !hold |=> !rx_full_r && tx_empty_r
        && state_r == spms_pkg::ST_IDLE)
        else $error("disable did not flush port");
    chk_clock_idle: assert property (is_master && !running |-> SCK_OUT == cpol)
        else $error("serial clock not at idle level");

    cov_master_byte: cover property (is_master && byte_done);
    cov_slave_byte: cover property (is_slave && byte_done);
    cov_mode_fault: cover property (mode_fault_flag_evt);
    cov_wire_master: cover property (is_master && swire && byte_done);

endmodule : spms_port

// ---- verif/spms_slave_model.sv ----
// behavioural far-side serial peripheral
`timescale 1ns/100ps
module spms_slave_model (
    // pins
    input wire logic sck,
    input wire logic ss_n,
    input wire logic mosi,
    output logic miso,
    // mode and data
    input wire logic cpha,
    input wire logic lsbf,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    int k = 0;
    // look just before the edge, as a real input's hold time would
    wire #1 mosi_d = mosi;
    initial miso = 1'h1;
    always @(negedge ss_n) begin
        k = 0;
        miso = lsbf ? tx_byte[0] : tx_byte[7];
    end
    // released line has no pull, so show the inverse
    always @(posedge ss_n) miso = ~miso;
    // either edge counts, so polarity only moves the idle level
    always @(sck) if (!ss_n) begin
        if (k[0] == cpha) rx_byte[lsbf ? k/2 : 7-k/2] = mosi_d;
        else if ((k+1)/2 < 8) miso = tx_byte[lsbf ? (k+1)/2 : 7-(k+1)/2];
        k++;
    end
endmodule : spms_slave_model

// ---- verif/spms_port_tb.sv ----
// self-checking bench for the serial port
`timescale 1ns/100ps
module spms_port_tb;
    logic clk = 0, rst = 1, stp = 0, hld = 0, psel = 0, pen = 0, pwr = 0, prdy, perr, e;
    logic [7:0] pa = 8'h00, c1, c2, br, tx, s, stx = 8'h00, srx;
    logic [31:0] pwd = 32'h0, prd, q;
    logic irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe, m_miso;
    logic t_sck = 0, t_mosi = 0, t_ss = 1, cpha = 0, lsbf = 0;
    int n_fail = 0, n_checks = 0, cyc = 0, h;
    // one row: ctrl1, ctrl2, baud, byte sent, byte answered
    logic [39:0] rows [4] = '{40'h5000_31A5_3C, 40'h5C00_1396_E1, 40'h5500_711F_80,
        40'h5B10_07C3_5A};
    wire sck_w = sck_oe ? sck_o : t_sck;
    wire mosi_w = mosi_oe ? mosi_o : t_mosi;
    wire miso_w = miso_oe ? miso_o : m_miso;
    wire ss_w = ss_oe ? ss_o : t_ss;
    spms_port uut (.REF_CLK(clk), .RST(rst), .STOP_SHALLOW(hld), .STOP_DEEP(stp),
        .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd),
        .PREADY(prdy), .PSLVERR(perr), .IRQ(irq), .SCK_IN(sck_w), .SCK_OUT(sck_o),
        .SCK_OE(sck_oe), .MOSI_IN(mosi_w), .MOSI_OUT(mosi_o), .MOSI_OE(mosi_oe),
        .MISO_IN(miso_w), .MISO_OUT(miso_o), .MISO_OE(miso_oe), .SS_IN(ss_w),
        .SS_OUT(ss_o), .SS_OE(ss_oe));
    spms_slave_model m (.sck(sck_w), .ss_n(ss_o), .mosi(mosi_w), .miso(m_miso),
        .cpha(cpha), .lsbf(lsbf), .tx_byte(stx), .rx_byte(srx));
    always #5 clk = ~clk;
    // the longest run is a few thousand cycles per slow byte
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] v, input logic [31:0] x);
        n_checks++;
        if (v !== x) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, v, x);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        pa <= a;
        pwd <= {24'h0, d};
        @(posedge clk);
        pen <= 1'h1;
        do @(posedge clk); while (prdy !== 1'h1);
        q = prd;
        e = perr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        chk({27'h0, sck_oe, mosi_oe, miso_oe, ss_oe, irq}, 32'h0);
        apb(0, spms_pkg::OFS_STAT, 0);
        chk(q, 32'h20);
        foreach (rows[i]) begin
            {c1, c2, br, tx, s} = rows[i];
            cpha <= c1[2];
            lsbf <= c1[0];
            stx <= s;
            apb(1, spms_pkg::OFS_CTRL2, c2);
            apb(1, spms_pkg::OFS_BAUD, br);
            apb(1, spms_pkg::OFS_CTRL1, c1);
            apb(1, spms_pkg::OFS_DATA, tx);
            wait (sck_o !== c1[3]);
            @(negedge clk);
            h = 0;
            while (sck_o === !c1[3]) begin
                @(negedge clk);
                h++;
            end
            chk(32'(h), ({29'h0, br[6:4]} + 32'h1) << br[2:0]);
            chk({29'h0, ss_oe, ss_o, mosi_oe}, {29'h0, c2[4] & c1[1], 2'h1});
            do apb(0, spms_pkg::OFS_STAT, 0); while (q[7] !== 1'h1);
            apb(0, spms_pkg::OFS_DATA, 0);
            chk(q, {24'h0, s});
            chk(32'(srx), 32'(tx));
            repeat (260) @(negedge clk);
            chk({30'h0, sck_o, ss_o}, {30'h0, c1[3], 1'h1});
        end
        // slave byte, mode 0, driven by the bench as master
        apb(1, spms_pkg::OFS_CTRL2, 0);
        apb(1, spms_pkg::OFS_CTRL1, 8'h40);
        s = 8'h69;
        apb(1, spms_pkg::OFS_DATA, s);
        tx = 8'hB4;
        t_ss <= 1'h0;
        repeat (8) @(posedge clk);
        for (int i = 7; i >= 0; i--) begin
            t_mosi <= tx[i];
            repeat (8) @(posedge clk);
            chk({30'h0, miso_oe, miso_o}, {30'h0, 1'h1, s[i]});
            t_sck <= 1'h1;
            repeat (8) @(posedge clk);
            t_sck <= 1'h0;
        end
        repeat (8) @(posedge clk);
        apb(0, spms_pkg::OFS_DATA, 0);
        chk(q, 32'hB4);
        apb(1, spms_pkg::OFS_CTRL2, 8'h09);
        @(negedge clk);
        chk({30'h0, mosi_oe, miso_oe}, 32'h1);
        apb(1, spms_pkg::OFS_CTRL2, 8'h01);
        @(negedge clk);
        chk(32'(miso_oe), 32'h0);
        apb(1, spms_pkg::OFS_CTRL1, 8'h50);
        @(negedge clk);
        chk({30'h0, mosi_oe, miso_oe}, 32'h0);
        apb(1, spms_pkg::OFS_CTRL2, 8'h09);
        @(negedge clk);
        chk({30'h0, mosi_oe, miso_oe}, 32'h2);
        // select held low while a master watches it
        apb(1, spms_pkg::OFS_CTRL2, 8'h10);
        apb(1, spms_pkg::OFS_CTRL1, 8'hD0);
        repeat (8) @(negedge clk);
        chk(32'(irq), 32'h1);
        apb(0, spms_pkg::OFS_STAT, 0);
        chk(q, 32'h30);
        apb(0, spms_pkg::OFS_CTRL1, 0);
        chk(q, 32'hC0);
        apb(1, spms_pkg::OFS_STAT, 8'h10);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        t_ss <= 1'h1;
        // abort with a full buffer; phase bit left alone
        apb(1, spms_pkg::OFS_CTRL2, 0);
        apb(1, spms_pkg::OFS_CTRL1, 8'h70);
        apb(1, spms_pkg::OFS_DATA, 8'h3C);
        apb(1, spms_pkg::OFS_DATA, 8'h5A);
        @(negedge clk);
        chk({30'h0, irq, ss_o}, 32'h0);
        apb(1, spms_pkg::OFS_CTRL1, 8'h30);
        apb(0, spms_pkg::OFS_STAT, 0);
        chk(q, 32'h20);
        chk({28'h0, sck_oe, mosi_oe, miso_oe, ss_oe}, 32'h0);
        apb(1, spms_pkg::OFS_CTRL1, 8'h70);
        repeat (20) @(negedge clk);
        chk({30'h0, irq, ss_o}, 32'h3);
        apb(0, 8'h14, 0);
        chk({e, q[30:0]}, 32'h80000000);
        apb(1, spms_pkg::OFS_CTRL2, 8'hFF);
        apb(0, spms_pkg::OFS_CTRL2, 0);
        chk(q, 32'h19);
        stp <= 1'h1;
        @(posedge clk);
        stp <= 1'h0;
        apb(0, spms_pkg::OFS_CTRL1, 0);
        chk(q, 32'h0);
        // shallow stop in mid-byte at the fastest rate, then resume
        apb(1, spms_pkg::OFS_CTRL1, 8'h50);
        apb(1, spms_pkg::OFS_DATA, 8'hC3);
        @(posedge clk);
        hld <= 1'h1;
        repeat (30) @(negedge clk);
        chk(32'(ss_o), 32'h0);
        @(posedge clk);
        hld <= 1'h0;
        repeat (40) @(negedge clk);
        apb(0, spms_pkg::OFS_STAT, 0);
        chk(q, 32'hA0);
        test_done();
    end
endmodule : spms_port_tb
